// ### verilog/csr_map.vh
`ifndef CSR_MAP_VH
`define CSR_MAP_VH

// Register offsets
`define CSR_SYNC_REF_CLK_CFG   8'h0e
`define CSR_ANALOG_IN_CFG      8'h11
`define CSR_FUSE_LOAD_CTL      8'h13
`define CSR_PAT_VALUE_LOW      8'h14
`define CSR_PAT_VALUE_MID      8'h15
`define CSR_PAT_MODE_HIGH      8'h16
`define CSR_SER_CLK_BUF_CTL    8'h18

// Reset values
`define CSR_RESET_VALUE        8'h00

// Fields of sync_reference_clock_config
`define CSR_SYNC_PIN_FUNC_BIT  7
`define CSR_SYNC_TRIGGER_BIT   6
`define CSR_SYNC_REG_EN_BIT    5
`define CSR_REFERENCE_CONTROL_SOURCE_BIT        3
`define CSR_REF_SEL_HI         2
`define CSR_REF_SEL_LO         1
`define CSR_SE_CLK_BIT         0

// Fields of other registers
`define CSR_SE_IN_A_BIT        5
`define CSR_FUSE_LOAD_BIT      0
`define CSR_PAT_MODE_HI        4
`define CSR_PAT_MODE_LO        2
`define CSR_PAT_HIGH_HI        1
`define CSR_PAT_HIGH_LO        0
`define CSR_SER_CLK_EN_BIT     4

// Reference selection codes
`define CSR_REF_INTERNAL       2'h0
`define CSR_REF_EXT_BUFFERED   2'h1
`define CSR_REF_EXTERNAL       2'h2

// Pattern mode codes
`define CSR_PAT_NORMAL         3'h0
`define CSR_PAT_RAMP           3'h2
`define CSR_PAT_CONSTANT       3'h3

// Widths
`define CSR_PAT_WIDTH          18
`define CSR_ADC_WIDTH          14

`endif

// ### verilog/csr_converter_regs.v
// Behaviour
// [RULE_01] Pin bit selects powerdown or sync on pin
// [RULE_02] Trigger bit toggle issues sync; host clears
// [RULE_03] Register sync enable replaces pin sync
// [RULE_04] Reference control picks pin or register source
// [RULE_05] Reference field: internal, buffered external, external
// [RULE_06] Single-ended clock bit powers down differential buffer; code applies it only when reference control selects register source
// [RULE_07] Analog register bit selects single-ended channel A
// [RULE_08] Host sets then clears fuse load bit
// [RULE_09] Fuse load resets other written registers
// [RULE_10] Pattern value assembled; constant output MSB aligned
// [RULE_11] Ramp uses pattern value as step
// [RULE_12] Pattern mode: normal, ramp, constant
// [RULE_13] Pattern inserted at native resolution, MSB aligned
// [RULE_14] Serial clock buffer enable bit
// [RULE_15] Trigger detected on zero-to-one transition only
`timescale 1ns/1ps
`include "csr_map.vh"

module csr_converter_regs (
    input  wire        clk_i,
    input  wire        resetn_i,
    input  wire        reg_wr_i,
    input  wire [7:0]  reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    output reg  [7:0]  reg_rdata_o,
    input  wire        sync_powerdown_pin_i,
    input  wire        reference_buffer_pin_i,
    input  wire [13:0] adc_data_i,
    output reg  [13:0] test_data_o,
    output reg         global_powerdown_o,
    output reg         sync_pulse_o,
    output reg  [1:0]  reference_select_o,
    output reg         single_ended_clock_select_o,
    output reg         diff_clock_buffer_pd_o,
    output reg         single_ended_input_chan_a_o,
    output reg         fuse_mapping_load_o,
    output reg         serial_clock_in_buffer_enable_o
);

    reg  [7:0]  sync_cfg_reg;
    reg  [7:0]  analog_cfg_reg;
    reg  [7:0]  fuse_ctl_reg;
    reg  [7:0]  pat_low_reg;
    reg  [7:0]  pat_mid_reg;
    reg  [7:0]  pat_high_reg;
    reg  [7:0]  ser_clk_reg;
    reg  [1:0]  pin_meta_reg;
    reg  [1:0]  pin_sync_reg;
    reg         sync_pin_prev_reg;
    reg         trigger_prev_reg;
    reg  [17:0] ramp_acc_reg;
    reg  [7:0]  rdata_next;
    reg  [13:0] test_data_next;

    wire [1:0]  pin_async     = {reference_buffer_pin_i, sync_powerdown_pin_i};
    wire        sync_pin_lvl  = pin_sync_reg[0];
    wire        ref_pin_lvl   = pin_sync_reg[1];
    wire        pin_is_sync   = sync_cfg_reg[`CSR_SYNC_PIN_FUNC_BIT];
    wire        reg_sync_en   = sync_cfg_reg[`CSR_SYNC_REG_EN_BIT];
    wire        reference_control_source       = sync_cfg_reg[`CSR_REFERENCE_CONTROL_SOURCE_BIT];
    wire        fuse_wr       = reg_wr_i && (reg_addr_i == `CSR_FUSE_LOAD_CTL);
    // Load fires when the bit is taken from one back to zero
    wire        fuse_fire     = fuse_wr && fuse_ctl_reg[`CSR_FUSE_LOAD_BIT] &&
                                !reg_wdata_i[`CSR_FUSE_LOAD_BIT]; // [RULE_08]
    wire [17:0] pattern_value = {pat_high_reg[`CSR_PAT_HIGH_HI:`CSR_PAT_HIGH_LO],
                                 pat_mid_reg, pat_low_reg}; // [RULE_10]
    wire [2:0]  pat_mode      = pat_high_reg[`CSR_PAT_MODE_HI:`CSR_PAT_MODE_LO];
    // Edge of the stored trigger, a held bit gives one sync only
    wire        trig_rise     = sync_cfg_reg[`CSR_SYNC_TRIGGER_BIT] && !trigger_prev_reg; // [RULE_15]
    wire        pin_rise      = sync_pin_lvl && !sync_pin_prev_reg;
    // Ramp wraps at full scale, carry dropped on purpose
    wire [18:0] ramp_sum      = {1'b0, ramp_acc_reg} + {1'b0, pattern_value};

    // Two flops per pin before any logic reads it
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_pin_sync
            always @(posedge clk_i) begin
                if (!resetn_i) begin
                    pin_meta_reg[g] <= 1'b0;
                    pin_sync_reg[g] <= 1'b0;
                end else begin
                    pin_meta_reg[g] <= pin_async[g];
                    pin_sync_reg[g] <= pin_meta_reg[g];
                end
            end
        end
    endgenerate

    // Register writes
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            sync_cfg_reg   <= `CSR_RESET_VALUE;
            analog_cfg_reg <= `CSR_RESET_VALUE;
            fuse_ctl_reg   <= `CSR_RESET_VALUE;
            pat_low_reg    <= `CSR_RESET_VALUE;
            pat_mid_reg    <= `CSR_RESET_VALUE;
            pat_high_reg   <= `CSR_RESET_VALUE;
            ser_clk_reg    <= `CSR_RESET_VALUE;
        end else if (fuse_fire) begin
            sync_cfg_reg   <= `CSR_RESET_VALUE; // [RULE_09]
            analog_cfg_reg <= `CSR_RESET_VALUE;
            fuse_ctl_reg   <= `CSR_RESET_VALUE;
            pat_low_reg    <= `CSR_RESET_VALUE;
            pat_mid_reg    <= `CSR_RESET_VALUE;
            pat_high_reg   <= `CSR_RESET_VALUE;
            ser_clk_reg    <= `CSR_RESET_VALUE;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `CSR_SYNC_REF_CLK_CFG) begin
                sync_cfg_reg <= reg_wdata_i;
            end else if (reg_addr_i == `CSR_ANALOG_IN_CFG) begin
                analog_cfg_reg <= reg_wdata_i;
            end else if (reg_addr_i == `CSR_FUSE_LOAD_CTL) begin
                fuse_ctl_reg <= reg_wdata_i;
            end else if (reg_addr_i == `CSR_PAT_VALUE_LOW) begin
                pat_low_reg <= reg_wdata_i;
            end else if (reg_addr_i == `CSR_PAT_VALUE_MID) begin
                pat_mid_reg <= reg_wdata_i;
            end else if (reg_addr_i == `CSR_PAT_MODE_HIGH) begin
                pat_high_reg <= reg_wdata_i;
            end else if (reg_addr_i == `CSR_SER_CLK_BUF_CTL) begin
                ser_clk_reg <= reg_wdata_i;
            end
        end
    end

    // Read mux, unmapped reads return zero
    always @* begin
        rdata_next = 8'h00;
        if (reg_addr_i == `CSR_SYNC_REF_CLK_CFG) begin
            rdata_next = sync_cfg_reg;
        end else if (reg_addr_i == `CSR_ANALOG_IN_CFG) begin
            rdata_next = analog_cfg_reg;
        end else if (reg_addr_i == `CSR_FUSE_LOAD_CTL) begin
            rdata_next = fuse_ctl_reg;
        end else if (reg_addr_i == `CSR_PAT_VALUE_LOW) begin
            rdata_next = pat_low_reg;
        end else if (reg_addr_i == `CSR_PAT_VALUE_MID) begin
            rdata_next = pat_mid_reg;
        end else if (reg_addr_i == `CSR_PAT_MODE_HIGH) begin
            rdata_next = pat_high_reg;
        end else if (reg_addr_i == `CSR_SER_CLK_BUF_CTL) begin
            rdata_next = ser_clk_reg;
        end
    end

    // Edge history and ramp accumulator
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            sync_pin_prev_reg <= 1'b0;
            trigger_prev_reg  <= 1'b0;
            ramp_acc_reg      <= 18'h00000;
        end else begin
            sync_pin_prev_reg <= sync_pin_lvl;
            trigger_prev_reg  <= sync_cfg_reg[`CSR_SYNC_TRIGGER_BIT];
            if (pat_mode == `CSR_PAT_RAMP) begin
                ramp_acc_reg <= ramp_sum[17:0]; // [RULE_11]
            end else begin
                ramp_acc_reg <= 18'h00000;
            end
        end
    end

    // Test pattern selection ahead of the test_data_o register
    always @* begin
        case (pat_mode) // [RULE_12]
            `CSR_PAT_RAMP: begin
                test_data_next = ramp_acc_reg[17:4]; // [RULE_13]
            end
            `CSR_PAT_CONSTANT: begin
                test_data_next = pattern_value[17:4]; // [RULE_10]
            end
            default: begin
                test_data_next = adc_data_i;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (!resetn_i) begin
            reg_rdata_o                     <= 8'h00;
            test_data_o                     <= 14'h0000;
            global_powerdown_o              <= 1'b0;
            sync_pulse_o                    <= 1'b0;
            reference_select_o              <= `CSR_REF_INTERNAL;
            single_ended_clock_select_o     <= 1'b0;
            diff_clock_buffer_pd_o          <= 1'b0;
            single_ended_input_chan_a_o     <= 1'b0;
            fuse_mapping_load_o             <= 1'b0;
            serial_clock_in_buffer_enable_o <= 1'b0;
        end else begin
            reg_rdata_o        <= rdata_next;
            test_data_o        <= test_data_next;
            global_powerdown_o <= !pin_is_sync && sync_pin_lvl; // [RULE_01]
            if (reg_sync_en) begin
                sync_pulse_o <= trig_rise; // [RULE_02] [RULE_03]
            end else begin
                sync_pulse_o <= pin_is_sync && pin_rise; // [RULE_01]
            end
            if (reference_control_source) begin
                // Unused code 11 falls back to internal reference
                if (sync_cfg_reg[`CSR_REF_SEL_HI:`CSR_REF_SEL_LO] == 2'h3) begin
                    reference_select_o <= `CSR_REF_INTERNAL; // [RULE_05]
                end else begin
                    reference_select_o <= sync_cfg_reg[`CSR_REF_SEL_HI:`CSR_REF_SEL_LO];
                end
                single_ended_clock_select_o <= sync_cfg_reg[`CSR_SE_CLK_BIT]; // [RULE_06]
                diff_clock_buffer_pd_o      <= sync_cfg_reg[`CSR_SE_CLK_BIT]; // [RULE_06]
            end else begin
                reference_select_o <= ref_pin_lvl ? `CSR_REF_EXTERNAL
                                                  : `CSR_REF_INTERNAL; // [RULE_04]
                single_ended_clock_select_o <= 1'b0;
                diff_clock_buffer_pd_o      <= 1'b0;
            end
            single_ended_input_chan_a_o     <= analog_cfg_reg[`CSR_SE_IN_A_BIT]; // [RULE_07]
            fuse_mapping_load_o             <= fuse_fire; // [RULE_08]
            serial_clock_in_buffer_enable_o <= ser_clk_reg[`CSR_SER_CLK_EN_BIT]; // [RULE_14]
        end
    end

endmodule

// ### verif/csr_regs_monitor.sv
`timescale 1ns/1ps
module csr_regs_monitor (
    input wire       clk_i,
    input wire       resetn_i,
    input wire       reg_wr_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire [7:0] reg_rdata_o,
    input wire       sync_powerdown_pin_i,
    input wire       global_powerdown_o,
    input wire       sync_pulse_o,
    input wire       single_ended_clock_select_o,
    input wire       diff_clock_buffer_pd_o,
    input wire       single_ended_input_chan_a_o,
    input wire       fuse_mapping_load_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sync_single_a: assert property (sync_pulse_o |=> !sync_pulse_o)
        else $error("sync pulse longer than one cycle");
    sync_cause_a: assert property (sync_pulse_o |-> $past(reg_wr_i, 2) ||
        $past(reg_wr_i, 3) || $past(sync_powerdown_pin_i, 3) || $past(sync_powerdown_pin_i, 4))
        else $error("sync pulse without cause");
    fuse_single_a: assert property (fuse_mapping_load_o |=> !fuse_mapping_load_o)
        else $error("fuse pulse longer than one cycle");
    fuse_cause_a: assert property (fuse_mapping_load_o |->
        $past(reg_wr_i && reg_addr_i == 8'h13 && !reg_wdata_i[0]))
        else $error("fuse pulse without clearing write");
    fuse_clear_a: assert property (fuse_mapping_load_o |=> !single_ended_input_chan_a_o)
        else $error("fuse load left a register set");
    unmapped_zero_a: assert property (reg_addr_i == 8'h17 |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    clk_tie_a: assert property (single_ended_clock_select_o == diff_clock_buffer_pd_o)
        else $error("clock select and buffer power down differ");
    se_clk_set_a: assert property (reg_wr_i && reg_addr_i == 8'h0e && reg_wdata_i[3] &&
        reg_wdata_i[0] ##1 !reg_wr_i |=> single_ended_clock_select_o && diff_clock_buffer_pd_o)
        else $error("single-ended clock not selected");
    pd_low_a: assert property (!sync_powerdown_pin_i [*4] |-> !global_powerdown_o)
        else $error("power down without pin");
    cover property (sync_pulse_o);
    cover property (fuse_mapping_load_o);
    cover property (global_powerdown_o);
endmodule
bind csr_converter_regs csr_regs_monitor mon (
    .clk_i                       (clk_i),
    .resetn_i                    (resetn_i),
    .reg_wr_i                    (reg_wr_i),
    .reg_addr_i                  (reg_addr_i),
    .reg_wdata_i                 (reg_wdata_i),
    .reg_rdata_o                 (reg_rdata_o),
    .sync_powerdown_pin_i        (sync_powerdown_pin_i),
    .global_powerdown_o          (global_powerdown_o),
    .sync_pulse_o                (sync_pulse_o),
    .single_ended_clock_select_o (single_ended_clock_select_o),
    .diff_clock_buffer_pd_o      (diff_clock_buffer_pd_o),
    .single_ended_input_chan_a_o (single_ended_input_chan_a_o),
    .fuse_mapping_load_o         (fuse_mapping_load_o)
);

// ### verif/csr_host_model.sv
`timescale 1ns/1ps
module csr_host_model (
    input  wire       clk_i,
    input  wire [7:0] rdata_i,
    output reg        wr_o,
    output reg  [7:0] addr_o,
    output reg  [7:0] wdata_o
);
    initial begin
        wr_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge clk_i);
            wr_o = 1'b1;
            addr_o = a;
            wdata_o = d;
            @(negedge clk_i);
            wr_o = 1'b0;
            wdata_o = ~d;
        end
    endtask
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(negedge clk_i);
            addr_o = a;
            @(negedge clk_i);
            d = rdata_i;
        end
    endtask
    // Set then clear, as the first step of any programming
    task fuse;
        begin
            wr(8'h13, 8'h01);
            wr(8'h13, 8'h00);
        end
    endtask
endmodule

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    reg         clk_i = 1'b0;
    reg         resetn_i = 1'b0;
    reg         pin = 1'b0;
    reg         refpin = 1'b0;
    reg  [13:0] adc = 14'h0000;
    reg  [17:0] pv;
    reg  [13:0] t;
    reg  [7:0]  d;
    reg  [31:0] rnd;
    wire        wr;
    wire [7:0]  addr, wdata, rdata;
    wire [13:0] tdata;
    wire [1:0]  rsel;
    wire        pd, syn, seclk, dpd, sea, fuse, sck;
    integer     seed = 57651, mismatches = 0, n_checks = 0, cyc = 0, ns = 0, nf = 0, i;
    csr_host_model host (.clk_i(clk_i), .rdata_i(rdata), .wr_o(wr), .addr_o(addr),
        .wdata_o(wdata));
    csr_converter_regs dut (.clk_i(clk_i), .resetn_i(resetn_i), .reg_wr_i(wr),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .sync_powerdown_pin_i(pin), .reference_buffer_pin_i(refpin), .adc_data_i(adc),
        .test_data_o(tdata), .global_powerdown_o(pd), .sync_pulse_o(syn),
        .reference_select_o(rsel), .single_ended_clock_select_o(seclk),
        .diff_clock_buffer_pd_o(dpd), .single_ended_input_chan_a_o(sea),
        .fuse_mapping_load_o(fuse), .serial_clock_in_buffer_enable_o(sck));
    initial forever #5 clk_i = ~clk_i;
    function [1:0] ref_exp(input [7:0] r, input p);
        ref_exp = r[3] ? ((r[2:1] == 2'h3) ? 2'h0 : r[2:1]) : (p ? 2'h2 : 2'h0);
    endfunction
    function mapped(input integer a);
        mapped = (a == 14 || a == 17 || (a > 18 && a != 23));
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", n_checks, mismatches);
            if (mismatches == 0 && n_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // Pulses counted mid-cycle, away from the edge that launches them
    always @(negedge clk_i) begin
        cyc = cyc + 1;
        if (syn === 1'b1) ns = ns + 1;
        if (fuse === 1'b1) nf = nf + 1;
        if (cyc == 4000) begin
            mismatches = mismatches + 1;
            finish_test;
        end
    end
    initial begin
        repeat (6) @(negedge clk_i);
        resetn_i = 1'b1;
        host.fuse;
        for (i = 14; i < 25; i = i + 1) begin
            host.rd(i[7:0], d);
            chk(d, 8'h00);
            rnd = $random(seed);
            pv = rnd[17:0];
            host.wr(i[7:0], pv[7:0]);
            host.rd(i[7:0], d);
            chk(d, mapped(i) ? pv[7:0] : 8'h00);
        end
        $display("test registers done");
        for (i = 0; i < 32; i = i + 1) begin
            d = {4'h0, i[3:0]};
            refpin = i[4];
            host.wr(8'h0e, d);
            repeat (4) @(negedge clk_i);
            chk(rsel, ref_exp(d, refpin));
            chk({seclk, dpd}, {2{d[3] & d[0]}});
        end
        $display("test reference done");
        ns = 0;
        host.wr(8'h0e, 8'h20);
        host.wr(8'h0e, 8'h60);
        host.wr(8'h0e, 8'h60);
        repeat (4) @(negedge clk_i);
        chk(ns, 1);
        host.wr(8'h0e, 8'h00);
        host.wr(8'h0e, 8'h40);
        host.wr(8'h0e, 8'h80);
        pin = 1'b1;
        repeat (8) @(negedge clk_i);
        chk(ns, 2);
        chk(pd, 0);
        host.wr(8'h0e, 8'h00);
        repeat (4) @(negedge clk_i);
        chk(pd, 1);
        pin = 1'b0;
        $display("test sync done");
        for (i = 0; i < 4; i = i + 1) begin
            rnd = $random(seed);
            pv = rnd[17:0];
            host.wr(8'h14, pv[7:0]);
            host.wr(8'h15, pv[15:8]);
            host.wr(8'h16, {3'h0, 3'h3, pv[17:16]});
            repeat (3) @(negedge clk_i);
            chk(tdata, pv[17:4]);
        end
        host.wr(8'h16, 8'h00);
        for (i = 0; i < 8; i = i + 1) begin
            if (i == 4) begin
                host.wr(8'h16, 8'h14);
            end
            rnd = $random(seed);
            adc = rnd[13:0];
            @(negedge clk_i);
            chk(tdata, adc);
        end
        host.wr(8'h14, 8'h10);
        host.wr(8'h15, 8'h00);
        host.wr(8'h16, 8'h08);
        repeat (3) @(negedge clk_i);
        for (i = 0; i < 4; i = i + 1) begin
            t = tdata + 14'h0001;
            @(negedge clk_i);
            chk(tdata, t);
        end
        $display("test pattern done");
        host.wr(8'h11, 8'h20);
        host.wr(8'h18, 8'h10);
        repeat (3) @(negedge clk_i);
        chk({sea, sck}, 2'h3);
        nf = 0;
        host.fuse;
        repeat (3) @(negedge clk_i);
        chk(nf, 1);
        chk({sea, sck}, 2'h0);
        host.rd(8'h11, d);
        chk(d, 8'h00);
        $display("test fuse done");
        host.wr(8'h11, 8'h20);
        resetn_i = 1'b0;
        repeat (2) @(negedge clk_i);
        resetn_i = 1'b1;
        host.rd(8'h11, d);
        chk({d, sea}, 9'h000);
        $display("test reset done");
        finish_test;
    end
endmodule
